// >>> serial_nvram_status_interface.sv
`timescale 1ns/1ns
module serial_nvram_status_interface #(
  parameter int ADDR_W = serial_nvram_pkg::ARRAY_ADDR_W
) (
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic                           csN,
  input  wire logic                           sck,
  input  wire logic                           si,
  input  wire logic                           holdN,
  input  wire logic                           wpN,
  output logic                                so,
  output logic                                soOe,
  output serial_nvram_pkg::status_view_t      statusView,
  output logic                                statusViewUpdated
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  generate
    if (ADDR_W != serial_nvram_pkg::ARRAY_ADDR_W)
    begin : g_bad_width
      $error("Address width must match the 16-bit guard decode");
    end
  endgenerate

  localparam int DEPTH = 2 ** ADDR_W;

  // ---------------------------------------------------------------
  // Link-side state (serial clock domain)
  // ---------------------------------------------------------------
  // array storage
  logic [7:0]                      mem [DEPTH];

  serial_nvram_pkg::phase_t        phase_r;
  serial_nvram_pkg::phase_t        phase_nxt;
  logic [2:0]                      bitCnt_r;
  logic [6:0]                      shift_r;
  logic                            frame_r;
  logic                            isWrite_r;
  logic [ADDR_W-1:0]               addr_r;
  logic [ADDR_W-1:0]               addr_nxt;
  logic [7:0]                      txByte_r;
  logic [7:0]                      txByte_nxt;
  logic                            soBit_r;

  logic                            armLatch_r;
  logic                            armLatch_nxt;
  logic [7:0]                      nvStatus_r;
  logic [7:0]                      nvStatus_nxt;
  logic                            endPending_r;
  logic                            endPending_nxt;
  logic                            sleepPending_r;
  logic                            sleepPending_nxt;
  logic                            deselTog_r;
  logic                            viewTog_r;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire        byteDone   = (bitCnt_r == 3'h7);
  wire [7:0]  rxByte     = {shift_r, si};
  wire        frameStart = !frame_r;
  wire [1:0]  guardPair  = nvStatus_r[serial_nvram_pkg::STAT_GUARD_HI_BIT:
                                      serial_nvram_pkg::STAT_GUARD_LO_BIT];
  wire        statusLock = nvStatus_r[serial_nvram_pkg::STAT_LOCK_BIT];
  // arm latch reads as cleared once its ending deselect has passed
  wire        armVisible = armLatch_r & ~endPending_r & ~sleepPending_r;
  wire [7:0]  statusByte = (nvStatus_r & serial_nvram_pkg::STAT_WRITE_MASK)
                           | {6'h00, armVisible, 1'b0};
  wire        statWrOk   = armLatch_r & (~statusLock | wpN);
  wire        arrWrOk    = armLatch_r & ~serial_nvram_pkg::guard_hit(guardPair, addr_r);
  wire        sending    = (phase_r == serial_nvram_pkg::PH_STAT_RD)
                           || (phase_r == serial_nvram_pkg::PH_ARRAY_RD);

  // ---------------------------------------------------------------
  // Command sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    phase_nxt        = phase_r;
    addr_nxt         = addr_r;
    txByte_nxt       = txByte_r;
    armLatch_nxt     = armLatch_r;
    nvStatus_nxt     = nvStatus_r;
    endPending_nxt   = endPending_r;
    sleepPending_nxt = sleepPending_r;

    // Deferred deselect effects are applied on the next frame's first edge
    if (frameStart)
    begin
      // end of status or array write clears the arm latch
      if (endPending_r)
        armLatch_nxt = 1'b0;
      endPending_nxt = 1'b0;
      // waking from sleep clears the arm latch
      if (sleepPending_r)
      begin
        armLatch_nxt     = 1'b0;
        sleepPending_nxt = 1'b0;
      end
    end
    else if (sleepPending_r)
      // Any clock after the sleep opcode cancels it
      sleepPending_nxt = 1'b0;

    if (byteDone)
    begin
      case (phase_r)
        serial_nvram_pkg::PH_OPCODE:
        begin
          case (rxByte)
            serial_nvram_pkg::OPC_ARM_WRITE:
            begin
              armLatch_nxt = 1'b1;
              phase_nxt    = serial_nvram_pkg::PH_IGNORE;
            end
            serial_nvram_pkg::OPC_DISARM_WRITE:
            begin
              armLatch_nxt = 1'b0;
              phase_nxt    = serial_nvram_pkg::PH_IGNORE;
            end
            serial_nvram_pkg::OPC_STATUS_READ:
            begin
              txByte_nxt = statusByte;
              phase_nxt  = serial_nvram_pkg::PH_STAT_RD;
            end
            serial_nvram_pkg::OPC_STATUS_WRITE:
            begin
              endPending_nxt = 1'b1;
              phase_nxt      = serial_nvram_pkg::PH_STAT_WR;
            end
            serial_nvram_pkg::OPC_ARRAY_READ,
            serial_nvram_pkg::OPC_ARRAY_WRITE:
            begin
              endPending_nxt = (rxByte == serial_nvram_pkg::OPC_ARRAY_WRITE);
              phase_nxt      = serial_nvram_pkg::PH_ADDR_HI;
            end
            serial_nvram_pkg::OPC_SLEEP:
            begin
              sleepPending_nxt = 1'b1;
              phase_nxt        = serial_nvram_pkg::PH_IGNORE;
            end
            default:
              phase_nxt = serial_nvram_pkg::PH_IGNORE;
          endcase
        end
        serial_nvram_pkg::PH_ADDR_HI:
        begin
          addr_nxt  = {rxByte, addr_r[7:0]};
          phase_nxt = serial_nvram_pkg::PH_ADDR_LO;
        end
        serial_nvram_pkg::PH_ADDR_LO:
        begin
          if (isWrite_r)
          begin
            addr_nxt  = {addr_r[ADDR_W-1:8], rxByte};
            phase_nxt = serial_nvram_pkg::PH_ARRAY_WR;
          end
          else
          begin
            // first array byte, address then steps with rollover
            txByte_nxt = mem[{addr_r[ADDR_W-1:8], rxByte}];
            addr_nxt   = {addr_r[ADDR_W-1:8], rxByte} + 1'b1;
            phase_nxt  = serial_nvram_pkg::PH_ARRAY_RD;
          end
        end
        serial_nvram_pkg::PH_ARRAY_RD:
        begin
          txByte_nxt = mem[addr_r];
          addr_nxt   = addr_r + 1'b1;
        end
        serial_nvram_pkg::PH_ARRAY_WR:
          // byte lands on its last edge, no busy period
          addr_nxt = addr_r + 1'b1;
        // status byte reloaded every eight clocks
        serial_nvram_pkg::PH_STAT_RD:
          txByte_nxt = statusByte;
        serial_nvram_pkg::PH_STAT_WR:
        begin
          // nonvolatile bits only; bits 1..0 written as zero
          if (statWrOk)
            nvStatus_nxt = rxByte & serial_nvram_pkg::STAT_WRITE_MASK;
          phase_nxt = serial_nvram_pkg::PH_IGNORE;
        end
        default:
          phase_nxt = serial_nvram_pkg::PH_IGNORE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame registers, cleared while deselected
  // ---------------------------------------------------------------
  wire frameClear = csN | ~reset_n;
  // chip select high discards any partial command
  // input sampled on rising edge in either idle level
  always_ff @(posedge sck or posedge frameClear)
  begin
    if (frameClear)
    begin
      phase_r   <= serial_nvram_pkg::PH_OPCODE;
      bitCnt_r  <= 3'h0;
      shift_r   <= 7'h00;
      frame_r   <= 1'b0;
      isWrite_r <= 1'b0;
      addr_r    <= '0;
      txByte_r  <= 8'h00;
    end
    else if (holdN)
    begin
      phase_r  <= phase_nxt;
      bitCnt_r <= bitCnt_r + 3'h1;
      shift_r  <= rxByte[6:0];
      frame_r  <= 1'b1;
      addr_r   <= addr_nxt;
      txByte_r <= txByte_nxt;
      if (byteDone && phase_r == serial_nvram_pkg::PH_OPCODE)
        isWrite_r <= (rxByte == serial_nvram_pkg::OPC_ARRAY_WRITE);
    end
  end

  // ---------------------------------------------------------------
  // Persistent state
  // ---------------------------------------------------------------
  // power-up clears the arm latch
  always_ff @(posedge sck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      armLatch_r     <= 1'b0;
      nvStatus_r     <= serial_nvram_pkg::STAT_NV_RESET;
      endPending_r   <= 1'b0;
      sleepPending_r <= 1'b0;
      viewTog_r      <= 1'b0;
    end
    else if (!csN && holdN)
    begin
      armLatch_r     <= armLatch_nxt;
      nvStatus_r     <= nvStatus_nxt;
      endPending_r   <= endPending_nxt;
      sleepPending_r <= sleepPending_nxt;
      // Flag every change so the system side can pick it up
      if ((armLatch_nxt != armLatch_r) || (nvStatus_nxt != nvStatus_r)
          || (sleepPending_nxt != sleepPending_r) || (endPending_nxt != endPending_r))
        viewTog_r <= ~viewTog_r;
    end
  end

  // An uncancelled sleep opcode takes effect at deselect, which has no
  // link clock edge, so the deselect edge flags the view change itself
  wire sleepNow = sleepPending_r & csN;
  always_ff @(posedge csN or negedge reset_n)
  begin
    if (!reset_n)
      deselTog_r <= 1'b0;
    else if (sleepPending_r)
      deselTog_r <= ~deselTog_r;
  end
  // Only one of the two toggles moves at a time, so the XOR is glitch free
  wire viewToggle = viewTog_r ^ deselTog_r;

  // Array has no reset: contents are nonvolatile
  always_ff @(posedge sck)
  begin
    if (!csN && holdN && byteDone && phase_r == serial_nvram_pkg::PH_ARRAY_WR
        && arrWrOk)
      mem[addr_r] <= rxByte;
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  // output changes on falling edge, MSB first
  always_ff @(negedge sck or posedge frameClear)
  begin
    if (frameClear)
      soBit_r <= 1'b0;
    else if (holdN)
      soBit_r <= txByte_r[~bitCnt_r];
  end

  assign so = soBit_r;
  // drive only when selected, unpaused and answering
  assign soOe = ~csN & holdN & sending;

  // ---------------------------------------------------------------
  // System-side view
  // ---------------------------------------------------------------
  serial_nvram_pkg::status_view_t viewLink;

  assign viewLink.sleeping = sleepNow;
  assign viewLink.status   = statusByte;

  status_view_crossing u_view_crossing (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .changeToggle (viewToggle),
    .viewIn       (viewLink),
    .viewOut      (statusView),
    .viewUpdated  (statusViewUpdated)
  );

endmodule : serial_nvram_status_interface

// >>> serial_nvram_pkg.sv
package serial_nvram_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ARRAY_ADDR_W = 16;
  localparam int ARRAY_BYTES  = 65536;
  localparam int BYTE_W       = 8;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ARM_WRITE    = 8'h06;
  localparam logic [7:0] OPC_DISARM_WRITE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE  = 8'h02;
  localparam logic [7:0] OPC_SLEEP        = 8'hb9;

  // ---------------------------------------------------------------
  // Protection status layout
  // ---------------------------------------------------------------
  localparam int STAT_LOCK_BIT     = 7;
  localparam int STAT_SPARE_HI     = 6;
  localparam int STAT_SPARE_LO     = 4;
  localparam int STAT_GUARD_HI_BIT = 3;
  localparam int STAT_GUARD_LO_BIT = 2;
  localparam int STAT_ARM_BIT      = 1;
  localparam int STAT_ZERO_BIT     = 0;
  // Bits that a status write may change
  localparam logic [7:0] STAT_WRITE_MASK = 8'hfc;
  localparam logic [7:0] STAT_NV_RESET   = 8'h00;

  // Block guard codes
  localparam logic [1:0] GUARD_NONE    = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF    = 2'h2;
  localparam logic [1:0] GUARD_ALL     = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_ARRAY_RD, PH_ARRAY_WR,
    PH_STAT_RD, PH_STAT_WR, PH_IGNORE
  } phase_t;

  typedef struct packed {
    logic       sleeping;
    logic [7:0] status;
  } status_view_t;

  // True when an array write to addr is shielded by the guard pair
  function automatic logic guard_hit(input logic [1:0]  guard,
                                     input logic [15:0] addr);
    case (guard)
      GUARD_NONE:    guard_hit = 1'b0;
      GUARD_QUARTER: guard_hit = (addr[15:14] == 2'h3);
      GUARD_HALF:    guard_hit = addr[15];
      default:       guard_hit = 1'b1;
    endcase
  endfunction : guard_hit

endpackage : serial_nvram_pkg

// >>> status_view_crossing.sv
`timescale 1ns/1ns
module status_view_crossing (
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic                           changeToggle,
  input  wire serial_nvram_pkg::status_view_t viewIn,
  output serial_nvram_pkg::status_view_t      viewOut,
  output logic                                viewUpdated
);

  logic                           togMeta_r;
  logic                           togSync_r;
  logic                           togSeen_r;
  serial_nvram_pkg::status_view_t viewOut_r;
  logic                           changed;

  // Toggle edge marks a new settled word on viewIn
  assign changed     = togSync_r ^ togSeen_r;
  assign viewOut     = viewOut_r;
  assign viewUpdated = changed;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      togMeta_r <= 1'b0;
      togSync_r <= 1'b0;
      togSeen_r <= 1'b0;
      viewOut_r <= '0;
    end
    else
    begin
      togMeta_r <= changeToggle;
      togSync_r <= togMeta_r;
      togSeen_r <= togSync_r;
      if (changed)
        viewOut_r <= viewIn;
    end
  end

endmodule : status_view_crossing

// >>> nvram_status_chk.sv
`timescale 1ns/1ns
module nvram_status_chk #(
  parameter int ADDR_W = 16
) (
  input wire logic                           ref_clk,
  input wire logic                           reset_n,
  input wire logic                           csN,
  input wire logic                           sck,
  input wire logic                           si,
  input wire logic                           holdN,
  input wire logic                           wpN,
  input wire logic                           so,
  input wire logic                           soOe,
  input wire serial_nvram_pkg::status_view_t statusView,
  input wire logic                           statusViewUpdated
);
  // ---------------------------------------------------------------
  // Frame bit counter, link side
  // ---------------------------------------------------------------
  // Wraps 15 -> 8 so each data byte shows the same phase
  logic [3:0] bitCnt;
  logic [7:0] opc;
  wire        rdStat = (opc == serial_nvram_pkg::OPC_STATUS_READ) && bitCnt[3];

  always_ff @(posedge sck or posedge csN or negedge reset_n)
    if (!reset_n)
    begin
      bitCnt <= 4'h0;
      opc    <= 8'h00;
    end
    else if (csN)
    begin
      bitCnt <= 4'h0;
      opc    <= 8'h00;
    end
    else if (holdN)
    begin
      bitCnt <= (bitCnt == 4'hf) ? 4'h8 : bitCnt + 4'h1;
      if (!bitCnt[3])
        opc <= {opc[6:0], si};
    end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_stat_opcode;
    (bitCnt == 4'h7) && ({opc[6:0], si} == serial_nvram_pkg::OPC_STATUS_READ) && holdN
    ##1 holdN;
  endsequence

  property p_deselect_float;
    @(posedge ref_clk) disable iff (!reset_n) csN |-> !soOe;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("output on while deselected");

  property p_hold_float;
    @(posedge ref_clk) disable iff (!reset_n) !holdN |-> !soOe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output on during pause");

  property p_view_bit0;
    @(posedge ref_clk) disable iff (!reset_n) statusView.status[0] == 1'b0;
  endproperty
  a_view_bit0: assert property (p_view_bit0) else $error("status bit 0 set");

  property p_idle_stable;
    @(posedge ref_clk) disable iff (!reset_n) csN [*8] |-> $stable(statusView.status);
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("status moved while idle");

  property p_stat_answer;
    @(posedge sck) disable iff (!reset_n || csN) s_stat_opcode |-> soOe;
  endproperty
  a_stat_answer: assert property (p_stat_answer) else $error("no status answer");

  property p_stat_repeat;
    @(posedge sck) disable iff (!reset_n || csN)
      rdStat && soOe |-> ##8 (!soOe || so == $past(so, 8));
  endproperty
  a_stat_repeat: assert property (p_stat_repeat) else $error("status not repeated");

  property p_so_bit0;
    @(posedge sck) disable iff (!reset_n || csN) rdStat && soOe && bitCnt == 4'hf |-> !so;
  endproperty
  a_so_bit0: assert property (p_so_bit0) else $error("status bit 0 shifted high");

  property p_quiet_opcode;
    @(posedge sck) disable iff (!reset_n || csN) !bitCnt[3] |-> !soOe;
  endproperty
  a_quiet_opcode: assert property (p_quiet_opcode) else $error("output during opcode");

  property p_view_update;
    @(posedge ref_clk) disable iff (!reset_n)
      $changed(statusView) |-> $past(statusViewUpdated);
  endproperty
  a_view_update: assert property (p_view_update) else $error("view moved without pulse");
endmodule : nvram_status_chk

bind serial_nvram_status_interface nvram_status_chk #(.ADDR_W(ADDR_W)) chkInst (
  .ref_clk(ref_clk), .reset_n(reset_n), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
  .wpN(wpN), .so(so), .soOe(soOe), .statusView(statusView),
  .statusViewUpdated(statusViewUpdated)
);

// >>> spi_master_model.sv
`timescale 1ns/1ns
module spi_master_model (
  input  wire logic refClk,
  output logic      csN,
  output logic      sck,
  output logic      si,
  output logic      holdN,
  output logic      wpN,
  input  wire logic so,
  input  wire logic soOe
);
  // ---------------------------------------------------------------
  // Frame tasks
  // ---------------------------------------------------------------
  logic mode3;

  initial
  begin
    csN   = 1'b1;
    sck   = 1'b0;
    si    = 1'b0;
    holdN = 1'b1;
    wpN   = 1'b0;
    mode3 = 1'b0;
  end

  // clock set to mode idle level first, then select
  task automatic open_frame();
    sck = mode3;
    @(negedge refClk) csN = 1'b0;
    #6;
  endtask : open_frame

  // data set while clock low, MSB first
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si  = tx[i];
      #6;
      sck   = 1'b1;
      rx[i] = soOe ? so : 1'bx;
      #6;
    end
  endtask : shift

  // Released data line shows the inverse, never the last bit
  task automatic close_frame();
    sck = mode3;
    // Two system clocks so a last-edge change is seen before deselect
    repeat (2) @(negedge refClk);
    csN = 1'b1;
    si = ~si;
  endtask : close_frame
endmodule : spi_master_model

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic                           refClk;
  logic                           resetN;
  wire                            csN, sck, si, holdN, wpN, so, soOe, viewUpd;
  serial_nvram_pkg::status_view_t view;
  int                             nErrors;
  int                             cmpCount;

  `define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); nErrors++; end end

  initial refClk = 1'b0;
  always #10 refClk = ~refClk;

  spi_master_model spi_master_model_inst (.refClk(refClk), .csN(csN), .sck(sck), .si(si),
    .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe));

  serial_nvram_status_interface serial_nvram_status_interface_inst (.ref_clk(refClk),
    .reset_n(resetN), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .so(so),
    .soOe(soOe), .statusView(view), .statusViewUpdated(viewUpd));

  // ---------------------------------------------------------------
  // Command helpers
  // ---------------------------------------------------------------
  task automatic frame(input logic [31:0] tx, input int nb, output logic [7:0] last);
    spi_master_model_inst.open_frame();
    for (int b = 0; b < nb; b++)
      spi_master_model_inst.shift(tx[31-8*b -: 8], 8, last);
    spi_master_model_inst.close_frame();
  endtask : frame

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    frame({op, 24'h0}, 1, rx);
  endtask : cmd

  task automatic wr_stat(input logic [7:0] v);
    logic [7:0] rx;
    cmd(serial_nvram_pkg::OPC_ARM_WRITE);
    frame({serial_nvram_pkg::OPC_STATUS_WRITE, v, 16'h0}, 2, rx);
  endtask : wr_stat

  task automatic check_stat(input logic [7:0] exp);
    logic [7:0] a;
    logic [7:0] b;
    spi_master_model_inst.open_frame();
    spi_master_model_inst.shift(serial_nvram_pkg::OPC_STATUS_READ, 8, a);
    spi_master_model_inst.shift(8'hff, 8, a);
    spi_master_model_inst.shift(8'h00, 8, b);
    spi_master_model_inst.close_frame();
    `CHK(a, exp)
    `CHK(b, exp)
  endtask : check_stat

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up();
    `CHK(view, 9'h000)
    check_stat(8'h00);
  endtask : t_power_up

  task automatic t_arm_modes();
    for (int m = 0; m < 2; m++)
    begin
      spi_master_model_inst.mode3 = m[0];
      cmd(serial_nvram_pkg::OPC_ARM_WRITE);
      repeat (8) @(posedge refClk);
      `CHK(view.status, 8'h02)
      check_stat(8'h02);
      cmd(serial_nvram_pkg::OPC_DISARM_WRITE);
      check_stat(8'h00);
    end
    spi_master_model_inst.mode3 = 1'b0;
  endtask : t_arm_modes

  task automatic t_status_write();
    logic [7:0] rx;
    wr_stat(8'hff);
    check_stat(8'hfc);
    repeat (8) @(posedge refClk);
    `CHK(view.status, 8'hfc)
    frame({serial_nvram_pkg::OPC_STATUS_WRITE, 24'h0}, 2, rx);
    check_stat(8'hfc);
    wr_stat(8'h00);
    check_stat(8'hfc);
    @(negedge refClk) spi_master_model_inst.wpN = 1'b1;
    wr_stat(8'h40);
    check_stat(8'h40);
    @(negedge refClk) spi_master_model_inst.wpN = 1'b0;
    wr_stat(8'h00);
    check_stat(8'h00);
  endtask : t_status_write

  task automatic t_partial();
    logic [7:0] rx;
    spi_master_model_inst.open_frame();
    spi_master_model_inst.shift(serial_nvram_pkg::OPC_ARM_WRITE, 7, rx);
    spi_master_model_inst.close_frame();
    check_stat(8'h00);
  endtask : t_partial

  // Clock and data toggle during the pause and must be dropped
  task automatic t_hold();
    logic [7:0] rx;
    spi_master_model_inst.open_frame();
    spi_master_model_inst.shift(serial_nvram_pkg::OPC_ARM_WRITE, 4, rx);
    spi_master_model_inst.holdN = 1'b0;
    spi_master_model_inst.shift(8'hff, 4, rx);
    `CHK(soOe, 1'b0)
    spi_master_model_inst.holdN = 1'b1;
    spi_master_model_inst.shift(8'h60, 4, rx);
    spi_master_model_inst.close_frame();
    check_stat(8'h02);
    cmd(serial_nvram_pkg::OPC_DISARM_WRITE);
  endtask : t_hold

  task automatic t_guard();
    logic [15:0] adr [3] = '{16'h0000, 16'h8000, 16'hc000};
    logic [7:0]  exp [3];
    logic [7:0]  rx;
    logic        hit;
    for (int g = 0; g < 4; g++)
    begin
      wr_stat({4'h0, g[1:0], 2'b00});
      for (int k = 0; k < 3; k++)
      begin
        hit = (g == 3) || (g == 2 && adr[k][15]) || (g == 1 && adr[k][15:14] == 2'h3);
        if (!hit)
          exp[k] = 8'h10 + 8'(g);
        cmd(serial_nvram_pkg::OPC_ARM_WRITE);
        frame({serial_nvram_pkg::OPC_ARRAY_WRITE, adr[k], 8'h10 + 8'(g)}, 4, rx);
        frame({serial_nvram_pkg::OPC_ARRAY_READ, adr[k], 8'h00}, 4, rx);
        `CHK(rx, exp[k])
      end
    end
    wr_stat(8'h00);
  endtask : t_guard

  task automatic t_sleep();
    logic [7:0] rx;
    spi_master_model_inst.mode3 = 1'b1;
    cmd(serial_nvram_pkg::OPC_ARM_WRITE);
    // A clock after the sleep opcode cancels it
    frame({serial_nvram_pkg::OPC_SLEEP, 24'h0}, 2, rx);
    check_stat(8'h02);
    cmd(serial_nvram_pkg::OPC_SLEEP);
    repeat (4) @(posedge refClk);
    `CHK(view.sleeping, 1'b1)
    spi_master_model_inst.open_frame();
    spi_master_model_inst.close_frame();
    check_stat(8'h00);
    `CHK(view.sleeping, 1'b0)
    spi_master_model_inst.mode3 = 1'b0;
  endtask : t_sleep

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    nErrors  = 0;
    cmpCount = 0;
    resetN   = 1'b0;
    repeat (3) @(posedge refClk);
    @(negedge refClk) resetN = 1'b1;
    t_power_up();
    t_arm_modes();
    t_status_write();
    t_partial();
    t_hold();
    t_guard();
    t_sleep();
    end_of_test();
  end

  initial
  begin
    // About ten times the expected run
    #200000;
    nErrors++;
    end_of_test();
  end
endmodule : testbench
